// ---- core/dpow_params.svh ----
// Purpose: Timing counts and widths for the DRAM power-down and leveling controller
// Assumes: Counts are in memory clock cycles (link clock edges)
// Notes: Included by the controller design file only; the package does not include it
`ifndef DPOW_PARAMS_SVH
`define DPOW_PARAMS_SVH
`define DPOW_ACT_PDEN 8'h01
`define DPOW_PRE_PDEN 8'h01
`define DPOW_RD_PDEN_ADD 8'h05
`define DPOW_BL8_ADD 8'h04
`define DPOW_BC4_ADD 8'h02
`define DPOW_WRA_ADD 8'h01
`define DPOW_ODTH4 8'h04
`define DPOW_ODTH8 8'h06
`define DPOW_WLMRD 8'h28
`define DPOW_WLDQSEN 8'h19
`define DPOW_CNT_W 8
`endif

// ---- core/dpow_pkg.sv ----
// Purpose: Types for the DRAM power-down and leveling controller
// Assumes: Nothing beyond the params header
// Notes: Command codes are user-side requests
package dpow_pkg;
  typedef enum logic [2:0] {
    DPOW_CMD_NOP, DPOW_CMD_ACT, DPOW_CMD_PRE, DPOW_CMD_RD,
    DPOW_CMD_WR, DPOW_CMD_WRA, DPOW_CMD_MRS, DPOW_CMD_WLVL
  } dpow_cmd_type;
  typedef enum logic [1:0] {
    DPOW_BURST_BL8, DPOW_BURST_BC4_OTF, DPOW_BURST_BC4_MRS
  } dpow_burst_type;
endpackage

// ---- core/dpow_sync.sv ----
// Purpose: Two-flop level synchroniser, one instance covers a whole WIDTH-bit bus
// Assumes: Input is a level, held long enough to be seen
// Notes: First stage is read only by the second
`timescale 1ns/10ps
module dpow_sync #(parameter int WIDTH = 1) (
  // Clock
  input wire logic clk,
  // Data
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] stage;
  always_ff @(posedge clk) begin
    stage <= din;
    dout <= stage;
  end
endmodule

// ---- core/dpow_ctrl.sv ----
// Purpose: Host-side DRAM controller that spaces commands before power-down,
//   drives termination control and runs write leveling strobes
// Assumes: clk_mem is the memory clock; the user side runs on clk_sys
// Notes: All spacing counts memory clock edges, never time
`timescale 1ns/10ps
`include "dpow_params.svh"
// Contract
// - Wait 1 cycle after activate before power-down entry.
// - Wait 1 cycle after precharge before power-down entry.
// - After read, wait read latency plus five cycles before power-down.
// - After write, wait WL plus recovery plus 4 or 2 by burst.
// - After auto-precharge write, wait WL plus WR plus one plus 4 or 2.
// - After mode register set, wait mode update delay before power-down.
// - Hold termination control high at least 4 cycles, or chop-4 write.
// - Hold termination control high 6 cycles with a burst-8 write.
// - First rising strobe edge at least 40 cycles after leveling set.
// - Strobe driven no sooner than 25 cycles after leveling set.
// - All spacing counted in actual clock edges.
module dpow_ctrl import dpow_pkg::*; (
  // System clock domain
  input wire logic clk_sys,
  input wire logic reset,
  // Memory clock domain
  input wire logic clk_mem,
  // User request, toggle handshake
  input wire logic req_toggle,
  input wire dpow_cmd_type req_cmd,
  input wire dpow_burst_type req_burst,
  input wire logic req_odt,
  input wire logic req_pd,
  output logic ack_toggle,
  // Latency settings, static while running
  input wire logic [4:0] read_latency,
  input wire logic [4:0] write_latency,
  input wire logic [4:0] write_recovery,
  input wire logic [4:0] mod_delay,
  // Memory pins
  output logic mem_cke,
  output logic [2:0] mem_cmd,
  output logic mem_odt,
  output logic mem_dqs_out,
  output logic mem_dqs_oe_n,
  input wire logic mem_dq0,
  // Status
  output logic pd_active,
  output logic level_sample
);
  // Request path into memory domain
  logic req_tog_m;
  logic req_seen;
  logic rst_m;
  logic [4:0] rl_m;
  logic [4:0] wl_m;
  logic [4:0] wr_m;
  logic [4:0] mod_m;
  dpow_sync #(.WIDTH(1)) u_sync_req (.clk(clk_mem), .din(req_toggle), .dout(req_tog_m));
  dpow_sync #(.WIDTH(1)) u_sync_rst (.clk(clk_mem), .din(reset), .dout(rst_m));
  dpow_sync #(.WIDTH(20)) u_sync_cfg (
    .clk(clk_mem),
    .din({read_latency, write_latency, write_recovery, mod_delay}),
    .dout({rl_m, wl_m, wr_m, mod_m})
  );
  // Fields are held stable by the user across the handshake
  dpow_cmd_type cmd_m;
  dpow_burst_type burst_m;
  logic odt_m;
  logic pd_m;
  dpow_sync #(.WIDTH(7)) u_sync_fld (
    .clk(clk_mem),
    .din({req_cmd, req_burst, req_odt, req_pd}),
    .dout({cmd_m, burst_m, odt_m, pd_m})
  );
  wire new_req = req_tog_m != req_seen;

  // Power-down guard counter
  logic [7:0] pd_wait;
  logic [7:0] next_pd_wait;
  wire [7:0] burst_add = (burst_m == DPOW_BURST_BC4_MRS) ? `DPOW_BC4_ADD : `DPOW_BL8_ADD;
  wire [7:0] wr_guard = 8'(wl_m) + burst_add + 8'(wr_m);
  wire [7:0] rd_guard = 8'(rl_m) + `DPOW_RD_PDEN_ADD;
  wire is_cmd = new_req && cmd_m != DPOW_CMD_NOP && cmd_m != DPOW_CMD_WLVL;
  logic [7:0] cmd_guard;
  always_comb begin
    cmd_guard = 8'h00;
    unique case (cmd_m)
      DPOW_CMD_ACT: cmd_guard = `DPOW_ACT_PDEN;
      DPOW_CMD_PRE: cmd_guard = `DPOW_PRE_PDEN;
      DPOW_CMD_RD: cmd_guard = rd_guard;
      DPOW_CMD_WR: cmd_guard = wr_guard;
      DPOW_CMD_WRA: cmd_guard = wr_guard + `DPOW_WRA_ADD;
      DPOW_CMD_MRS: cmd_guard = 8'(mod_m);
      DPOW_CMD_NOP: cmd_guard = 8'h00;
      DPOW_CMD_WLVL: cmd_guard = 8'(mod_m);
    endcase
  end
  // Count each memory clock edge; longest outstanding guard wins
  always_comb begin
    next_pd_wait = (pd_wait != 8'h00) ? pd_wait - 8'h01 : 8'h00;
    if (is_cmd && cmd_guard > next_pd_wait) begin
      next_pd_wait = cmd_guard;
    end
  end
  wire pd_allowed = pd_wait == 8'h00 && !is_cmd;

  // Termination hold counter
  logic [7:0] odt_hold;
  logic [7:0] next_odt_hold;
  wire odt_start = new_req && odt_m && !mem_odt;
  wire bl8_write = (cmd_m == DPOW_CMD_WR || cmd_m == DPOW_CMD_WRA) &&
                   burst_m == DPOW_BURST_BL8;
  wire [7:0] odt_min = bl8_write ? `DPOW_ODTH8 : `DPOW_ODTH4;
  always_comb begin
    next_odt_hold = (odt_hold != 8'h00) ? odt_hold - 8'h01 : 8'h00;
    if (new_req && odt_m && odt_min > next_odt_hold) begin
      next_odt_hold = odt_min;
    end
  end
  // Termination falls only once the hold has expired
  wire next_odt = (new_req && odt_m) ? 1'b1 :
                  (odt_hold > 8'h01) ? 1'b1 :
                  (new_req && !odt_m) ? 1'b0 :
                  (odt_hold == 8'h01) ? mem_odt : mem_odt;

  // Write leveling
  logic lvl_on;
  logic [7:0] lvl_cnt;
  wire lvl_start = new_req && cmd_m == DPOW_CMD_WLVL;
  wire dqs_enable = lvl_on && lvl_cnt >= `DPOW_WLDQSEN;
  wire dqs_rise_ok = lvl_on && lvl_cnt >= `DPOW_WLMRD;
  logic dq_s1;
  logic dq_s2;

  // Power-down request honoured only when the guard has expired
  wire next_cke = (new_req && pd_m && pd_allowed) ? 1'b0 :
                  (new_req && !pd_m) ? 1'b1 : mem_cke;

  always_ff @(posedge clk_mem) begin
    if (rst_m) begin
      req_seen <= 1'b0;
      pd_wait <= 8'h00;
      odt_hold <= 8'h00;
      mem_odt <= 1'b0;
      mem_cke <= 1'b1;
      mem_cmd <= 3'h0;
      lvl_on <= 1'b0;
      lvl_cnt <= 8'h00;
      mem_dqs_out <= 1'b0;
      mem_dqs_oe_n <= 1'b1;
    end else begin
      req_seen <= req_tog_m;
      pd_wait <= next_pd_wait;
      odt_hold <= next_odt_hold;
      mem_odt <= next_odt;
      mem_cke <= next_cke;
      // Leveling entry goes out as a command so the device can time its delays
      mem_cmd <= (is_cmd || lvl_start) ? 3'(cmd_m) : 3'h0;
      if (lvl_start) begin
        lvl_on <= 1'b1;
        lvl_cnt <= 8'h00;
      end else if (new_req && cmd_m == DPOW_CMD_MRS) begin
        lvl_on <= 1'b0;
      end else if (lvl_on && lvl_cnt != 8'hFF) begin
        lvl_cnt <= lvl_cnt + 8'h01;
      end
      mem_dqs_oe_n <= !dqs_enable;
      mem_dqs_out <= dqs_rise_ok ? !mem_dqs_out : 1'b0;
    end
  end

  // Device reply on prime data line, from the far clock edge
  always_ff @(posedge clk_mem) begin
    dq_s1 <= mem_dq0;
    dq_s2 <= dq_s1;
  end

  // Acknowledge and status back to the system domain
  logic [2:0] back_m;
  always_ff @(posedge clk_mem) begin
    back_m <= {req_seen, !mem_cke, dq_s2};
  end
  logic [2:0] back_s;
  dpow_sync #(.WIDTH(3)) u_sync_back (.clk(clk_sys), .din(back_m), .dout(back_s));
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ack_toggle <= 1'b0;
      pd_active <= 1'b0;
      level_sample <= 1'b0;
    end else begin
      ack_toggle <= back_s[2];
      pd_active <= back_s[1];
      level_sample <= back_s[0];
    end
  end

  // Checks on the memory side
  logic [7:0] cke_guard_seen;
  always_ff @(posedge clk_mem) begin
    if (rst_m) begin
      cke_guard_seen <= 8'h00;
    end else begin
      cke_guard_seen <= pd_wait;
    end
  end
  sequence s_odt_rise;
    !mem_odt ##1 mem_odt;
  endsequence
  sequence s_lvl_go;
    lvl_start ##1 lvl_on;
  endsequence
  chk_act_pd_gap: assert property (@(posedge clk_mem) disable iff (rst_m)
    (is_cmd && cmd_m == DPOW_CMD_ACT) |=> mem_cke || $past(!mem_cke))
    else $error("power-down entered too soon after activate");
  chk_pre_guard_set: assert property (@(posedge clk_mem) disable iff (rst_m)
    (is_cmd && cmd_m == DPOW_CMD_PRE) |=> pd_wait >= `DPOW_PRE_PDEN)
    else $error("precharge guard not loaded");
  chk_rd_guard_val: assert property (@(posedge clk_mem) disable iff (rst_m)
    (is_cmd && cmd_m == DPOW_CMD_RD) |=> pd_wait >= 8'(rl_m) + 8'h05)
    else $error("read guard too short");
  chk_wr_guard_val: assert property (@(posedge clk_mem) disable iff (rst_m)
    (is_cmd && cmd_m == DPOW_CMD_WR && burst_m == DPOW_BURST_BC4_MRS)
    |=> pd_wait >= 8'(wl_m) + 8'(wr_m) + 8'h02)
    else $error("write guard too short");
  chk_wra_guard_val: assert property (@(posedge clk_mem) disable iff (rst_m)
    (is_cmd && cmd_m == DPOW_CMD_WRA && burst_m == DPOW_BURST_BL8)
    |=> pd_wait >= 8'(wl_m) + 8'(wr_m) + 8'h05)
    else $error("auto-precharge write guard too short");
  chk_pd_no_early: assert property (@(posedge clk_mem) disable iff (rst_m)
    ($fell(mem_cke)) |-> $past(pd_wait) == 8'h00)
    else $error("power-down entered with guard running");
  chk_odt_hold4: assert property (@(posedge clk_mem) disable iff (rst_m)
    s_odt_rise |-> mem_odt [*4])
    else $error("termination control held under four cycles");
  chk_odt_hold8: assert property (@(posedge clk_mem) disable iff (rst_m)
    (odt_start && bl8_write) |=> mem_odt [*6])
    else $error("termination control held under six cycles");
  // Counter carries the long wait, so the property stays short
  chk_lvl_dqs_en: assert property (@(posedge clk_mem) disable iff (rst_m)
    $fell(mem_dqs_oe_n) |-> $past(lvl_cnt) >= `DPOW_WLDQSEN)
    else $error("strobe driven before enable delay");
  chk_lvl_cnt_clear: assert property (@(posedge clk_mem) disable iff (rst_m)
    s_lvl_go |-> lvl_cnt == 8'h00)
    else $error("leveling counter not cleared at entry");
  chk_lvl_first_rise: assert property (@(posedge clk_mem) disable iff (rst_m)
    $rose(mem_dqs_out) |-> $past(lvl_cnt) >= `DPOW_WLMRD)
    else $error("strobe rose before leveling delay");
  chk_guard_ticks: assert property (@(posedge clk_mem) disable iff (rst_m)
    (pd_wait > 8'h01 && !is_cmd) |=> pd_wait == $past(pd_wait) - 8'h01)
    else $error("guard not counting clock edges");
endmodule

// ---- test/dpow_dev_model.sv ----
// Purpose: Memory device model facing the controller pins
// Assumes: write_latency is at least 3
// Notes: Feedback line toggles whenever no strobe is driven
`timescale 1ns/10ps
module dpow_dev_model (
  // Clock and latency
  input wire logic clk_mem,
  input wire logic [4:0] write_latency,
  // Controller pins
  input wire logic mem_cke,
  input wire logic mem_odt,
  input wire logic mem_dqs_out,
  input wire logic mem_dqs_oe_n,
  // Device side
  output logic mem_dq0,
  output logic rtt_on
);
  logic [31:0] odt_pipe = 32'h0;
  logic odt_late = 1'b0;
  logic lvl = 1'b0;
  logic pat = 1'b0;
  // Edges, not time, from the edge that registers control
  always @(posedge clk_mem) odt_pipe <= {odt_pipe[30:0], mem_odt};
  always @(posedge clk_mem) pat <= ~pat;
  // Frozen-loop power-down switches inside the 2 to 8.5 ns window
  always @(mem_odt) odt_late <= #5 mem_odt;
  // On and off both after CWL = WL-2 edges
  assign rtt_on = mem_cke ? odt_pipe[write_latency - 5'h03] : odt_late;
  // Clock level seen at strobe rise goes back on the prime line
  always @(posedge mem_dqs_out) lvl <= clk_mem;
  assign mem_dq0 = mem_dqs_oe_n ? pat : lvl;
endmodule

// ---- test/tb_top.sv ----
// Purpose: Self-checking bench for the power-down and leveling controller
// Assumes: Latency settings static for the whole run
// Notes: Spacing measured in memory clock edges by a monitor
`timescale 1ns/10ps
module tb_top import dpow_pkg::*;;
  logic clk_sys = 1'b0, clk_mem = 1'b0, reset = 1'b1, req_toggle = 1'b0;
  logic req_odt = 1'b0, req_pd = 1'b0;
  dpow_cmd_type req_cmd = DPOW_CMD_NOP;
  dpow_burst_type req_burst = DPOW_BURST_BL8;
  logic ack_toggle, mem_cke, mem_odt, mem_dqs_out, mem_dqs_oe_n, mem_dq0;
  logic pd_active, level_sample, rtt_on;
  logic [2:0] mem_cmd;
  logic [31:0] gap = 32'h0, pd_gap = 32'h0, en_gap = 32'h0, rise_gap = 32'h0;
  logic [31:0] odt_len = 32'h0, odt_hi = 32'h0;
  logic cke_q = 1'b1, oe_q = 1'b1, dqs_q = 1'b0, odt_q = 1'b0, rise_seen = 1'b0;
  int mismatches = 0, checks_done = 0;
  localparam logic [4:0] RL = 5'h06, WL = 5'h05, WR = 5'h06, MD = 5'h0C;
  always #20 clk_sys = ~clk_sys;
  // Odd offset keeps the link clock off the system edges
  always begin
    #73;
    clk_mem = ~clk_mem;
    #7;
  end
  dpow_ctrl u_dpow_ctrl (.clk_sys(clk_sys), .reset(reset), .clk_mem(clk_mem),
    .req_toggle(req_toggle), .req_cmd(req_cmd), .req_burst(req_burst), .req_odt(req_odt),
    .req_pd(req_pd), .ack_toggle(ack_toggle), .read_latency(RL), .write_latency(WL),
    .write_recovery(WR), .mod_delay(MD), .mem_cke(mem_cke), .mem_cmd(mem_cmd),
    .mem_odt(mem_odt), .mem_dqs_out(mem_dqs_out), .mem_dqs_oe_n(mem_dqs_oe_n),
    .mem_dq0(mem_dq0), .pd_active(pd_active), .level_sample(level_sample));
  dpow_dev_model u_dpow_dev_model (.clk_mem(clk_mem), .write_latency(WL), .mem_cke(mem_cke),
    .mem_odt(mem_odt), .mem_dqs_out(mem_dqs_out), .mem_dqs_oe_n(mem_dqs_oe_n),
    .mem_dq0(mem_dq0), .rtt_on(rtt_on));
  // Gap counts edges since the device registered the last command
  always @(posedge clk_mem) begin
    gap <= (mem_cmd != 3'h0) ? 32'h1 : gap + 32'h1;
    rise_seen <= (mem_cmd != 3'h0) ? 1'b0 : rise_seen | (mem_dqs_out & ~dqs_q);
    if (cke_q && !mem_cke) pd_gap <= gap;
    if (oe_q && !mem_dqs_oe_n) en_gap <= gap;
    if (!rise_seen && mem_dqs_out && !dqs_q) rise_gap <= gap;
    if (odt_q && !mem_odt) odt_hi <= odt_len;
    odt_len <= mem_odt ? odt_len + 32'h1 : 32'h0;
    {cke_q, oe_q, dqs_q, odt_q} <= {mem_cke, mem_dqs_oe_n, mem_dqs_out, mem_odt};
  end
  task automatic final_report();
    $display("checks %0d, mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic mem_wait(input int k);
    repeat (k) @(posedge clk_mem);
    @(posedge clk_sys);
    #1;
  endtask
  task automatic send(input dpow_cmd_type c, input dpow_burst_type b, input logic o,
    input logic p);
    int n;
    req_cmd = c;
    req_burst = b;
    req_odt = o;
    req_pd = p;
    req_toggle = ~req_toggle;
    n = 0;
    while (ack_toggle !== req_toggle && n < 400) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    if (n >= 400) begin
      mismatches++;
      $display("mismatch at %0t: no acknowledge", $time);
      final_report();
    end
  endtask
  // Early entry requests must be refused until the guard runs out
  task automatic pd_guard(input dpow_cmd_type c, input dpow_burst_type b, input int exp);
    int n;
    send(c, b, 1'b0, 1'b0);
    n = 0;
    while (mem_cke !== 1'b0 && n < 40) begin
      send(DPOW_CMD_NOP, b, 1'b0, 1'b1);
      n++;
    end
    mem_wait(2);
    check(n < 40, 1'b1);
    check(pd_gap >= exp, 1'b1);
    check(pd_active, 1'b1);
    send(DPOW_CMD_NOP, b, 1'b0, 1'b0);
    mem_wait(4);
    check(mem_cke, 1'b1);
  endtask
  task automatic odt_hold(input dpow_cmd_type c, input dpow_burst_type b, input int exp);
    int n;
    send(c, b, 1'b1, 1'b0);
    n = 0;
    while (mem_odt !== 1'b0 && n < 20) begin
      send(DPOW_CMD_NOP, b, 1'b0, 1'b0);
      n++;
    end
    mem_wait(2);
    check(n < 20, 1'b1);
    check(odt_hi >= exp, 1'b1);
  endtask
  task automatic test_pd();
    pd_guard(DPOW_CMD_ACT, DPOW_BURST_BL8, 1);
    pd_guard(DPOW_CMD_PRE, DPOW_BURST_BL8, 1);
    pd_guard(DPOW_CMD_RD, DPOW_BURST_BL8, RL + 5);
    pd_guard(DPOW_CMD_WR, DPOW_BURST_BL8, WL + WR + 4);
    pd_guard(DPOW_CMD_WR, DPOW_BURST_BC4_OTF, WL + WR + 4);
    pd_guard(DPOW_CMD_WR, DPOW_BURST_BC4_MRS, WL + WR + 2);
    pd_guard(DPOW_CMD_WRA, DPOW_BURST_BL8, WL + WR + 5);
    pd_guard(DPOW_CMD_WRA, DPOW_BURST_BC4_MRS, WL + WR + 3);
    $display("test done: power-down guards");
  endtask
  task automatic test_odt();
    odt_hold(DPOW_CMD_NOP, DPOW_BURST_BL8, 4);
    odt_hold(DPOW_CMD_WR, DPOW_BURST_BC4_OTF, 4);
    odt_hold(DPOW_CMD_WR, DPOW_BURST_BL8, 6);
    $display("test done: termination hold");
  endtask
  task automatic test_level();
    send(DPOW_CMD_WLVL, DPOW_BURST_BL8, 1'b0, 1'b0);
    mem_wait(60);
    check(en_gap >= 25, 1'b1);
    check(rise_gap >= 40, 1'b1);
    check(level_sample, mem_dq0);
    pd_guard(DPOW_CMD_MRS, DPOW_BURST_BL8, MD);
    check(mem_dqs_oe_n, 1'b1);
    $display("test done: write leveling");
  endtask
  initial begin
    repeat (16) @(posedge clk_sys);
    #1;
    reset = 1'b0;
    mem_wait(4);
    test_pd();
    test_odt();
    test_level();
    final_report();
  end
endmodule
